// file: core/timer_trio_pkg.sv
// timer trio package: register map, field positions, reset values, bus carriers
// assumes a nibble-wide register port driven by the cpu core, one clock domain
package timer_trio_pkg;

	// ----------------------------------------------------------------
	// register offsets (nibble addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_FLAGS_A = 4'h1;
	localparam logic [3:0] ADDR_FLAGS_BC = 4'h2;
	localparam logic [3:0] ADDR_WDOG = 4'h3;
	localparam logic [3:0] ADDR_PORT_SEL_B = 4'h5;
	localparam logic [3:0] ADDR_MODE_A = 4'h8;
	localparam logic [3:0] ADDR_MODE_B = 4'h9;
	localparam logic [3:0] ADDR_TB_LO = 4'ha;
	localparam logic [3:0] ADDR_TB_HI = 4'hb;
	localparam logic [3:0] ADDR_MODE_C = 4'hd;
	localparam logic [3:0] ADDR_TC_LO = 4'he;
	localparam logic [3:0] ADDR_TC_HI = 4'hf;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int FLAG_A_BIT = 2;
	localparam int FLAG_B_BIT = 0;
	localparam int FLAG_C_BIT = 2;
	localparam int WATCH_BASE_BIT = 3;
	localparam int RELOAD_BIT = 3;
	localparam int WDOG_BIT = 0;
	localparam int PORT_SEL_TIMER_OUT_BIT = 2;

	// ----------------------------------------------------------------
	// reset values and special codes
	// ----------------------------------------------------------------
	localparam logic [10:0] PS_RESET = 11'h000;
	localparam logic [4:0] SUBPS_RESET = 5'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_TOP = 8'hff;
	localparam logic [7:0] PWM_MID_BASE = 8'h80;
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [2:0] SUB_DIV_TOP = 3'h7;
	localparam logic [2:0] EXT_EVENT_CODE = 3'h7;
	localparam logic [2:0] WBASE_HALF_CODE = 3'h4;
	localparam logic [1:0] WBASE_CLEAR_CODE = 2'h3;

	// register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [3:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// power state from the mode controller
	typedef struct packed {
		logic stop;
		logic watch;
	} power_mode_t;

endpackage : timer_trio_pkg

// file: core/prescaled_timer_trio.sv
// prescalers s and w plus timers a, b and c with flags, watchdog and pwm output
// assumes all inputs synchronous to clock_i; reset is the mcu reset
//
// Behaviour
// [RQ1] prescaler s clears at reset and counts from release
// [RQ2] prescaler s counts always except reset, stop and watch modes
// [RQ3] prescaler s taps feed timers a, b, c and serial clock
// [RQ4] prescaler w counts sub-oscillator divided by eight, feeds timer a
// [RQ5] timer a resets to zero, counts ticks, wraps from ff with overflow
// [RQ6] timer a overflow sets timer a flag, word 1 bit 2
// [RQ7] timer a overflows every 256 input ticks
// [RQ8] watch base select bit routes prescaler w to timer a
// [RQ9] watch-base clear code zeroes prescaler w and timer a
// [RQ10] timer a mode register at 8 selects source and rate
// [RQ11] timer b mode register at 9 selects reload, ratio, source
// [RQ12] software routes shared pin as event input to avoid interrupts
// [RQ13] writing timer b load loads the counter, then counting resumes
// [RQ14] timer b overflows after ff, reloads or goes to zero
// [RQ15] timer b overflow sets flag word 2 bit 0
// [RQ16] timer c mode register at d selects reload and ratio
// [RQ17] timer c loads on write, overflows after ff, reloads or zero
// [RQ18] timer c overflow sets flag word 2 bit 2
// [RQ19] watchdog enabled: timer c overflow requests full mcu reset
// [RQ20] watchdog stops with timer c, stays active in standby
// [RQ21] timer c drives pwm output, stops when timer c stops
// [RQ22] software sets port select b bit 2 for timer output
// [RQ23] timer a mode codes select s or w periods or clear
// [RQ24] timer b bit 3 reload, codes 0-6 ratios, 7 external event
// [RQ25] load low nibble first; counter loads at high nibble write
// [RQ26] high counter read latches low nibble for following read
// [RQ27] pwm high at overflow, low at midpoint of reload span
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module prescaled_timer_trio (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// register port
	input wire timer_trio_pkg::reg_req_t req_i,
	output logic [3:0] rdata_o,
	// power state
	input wire timer_trio_pkg::power_mode_t power_i,
	// serial clock selection
	input wire logic [2:0] serial_mode_register_i,
	output logic serial_tick_o,
	// external pins
	input wire logic sub_oscillator_input_i,
	input wire logic external_event_input_i,
	output logic pulse_output_pin_o,
	output logic pulse_output_en_o,
	// interrupt flags and watchdog
	output logic [2:0] irq_flags_o,
	output logic watchdog_reset_o
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------

	// true when the low k bits are all ones: carry into bit k
	function automatic logic tap(input logic [10:0] cnt, input logic [3:0] k);
		logic [10:0] mask;
		mask = 11'((12'h001 << k) - 12'h001);
		tap = ((cnt & mask) == mask);
	endfunction : tap

	// divide 2048,1024,512,128,32,8,4,2 as shift counts
	function automatic logic [3:0] shift_ac(input logic [2:0] code);
		case (code)
			3'h0: shift_ac = 4'hb;
			3'h1: shift_ac = 4'ha;
			3'h2: shift_ac = 4'h9;
			3'h3: shift_ac = 4'h7;
			3'h4: shift_ac = 4'h5;
			3'h5: shift_ac = 4'h3;
			3'h6: shift_ac = 4'h2;
			default: shift_ac = 4'h1;
		endcase
	endfunction : shift_ac

	// divide 2048,512,128,32,8,4,2 as shift counts
	function automatic logic [3:0] shift_b(input logic [2:0] code);
		case (code)
			3'h0: shift_b = 4'hb;
			3'h1: shift_b = 4'h9;
			3'h2: shift_b = 4'h7;
			3'h3: shift_b = 4'h5;
			3'h4: shift_b = 4'h3;
			3'h5: shift_b = 4'h2;
			default: shift_b = 4'h1;
		endcase
	endfunction : shift_b

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	logic [3:0] timer_a_mode;
	logic [3:0] timer_b_mode;
	logic [3:0] timer_c_mode;
	logic [3:0] port_select_mode_b;
	logic watchdog_enable_flag;

	// timer mode registers are write-only; they read as zero
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			timer_a_mode <= timer_trio_pkg::MODE_RESET;
			timer_b_mode <= timer_trio_pkg::MODE_RESET;
			timer_c_mode <= timer_trio_pkg::MODE_RESET;
			port_select_mode_b <= timer_trio_pkg::MODE_RESET;
			watchdog_enable_flag <= 1'b0;
		end else if (req_i.wr) begin
			case (req_i.addr)
				timer_trio_pkg::ADDR_MODE_A: timer_a_mode <= req_i.wdata; // RQ10
				timer_trio_pkg::ADDR_MODE_B: timer_b_mode <= req_i.wdata; // RQ11
				timer_trio_pkg::ADDR_MODE_C: timer_c_mode <= req_i.wdata; // RQ16
				timer_trio_pkg::ADDR_PORT_SEL_B: port_select_mode_b <= req_i.wdata;
				timer_trio_pkg::ADDR_WDOG: watchdog_enable_flag <= req_i.wdata[timer_trio_pkg::WDOG_BIT];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// prescaler s
	// ----------------------------------------------------------------
	logic [10:0] system_clock_prescaler;
	logic ps_run;

	assign ps_run = !power_i.stop && !power_i.watch; // RQ2

	// free running, frozen only in stop and watch
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			system_clock_prescaler <= timer_trio_pkg::PS_RESET; // RQ1
		end else if (ps_run) begin
			system_clock_prescaler <= system_clock_prescaler + 11'h001; // RQ2
		end
	end

	// serial transmit clock tap, same ratio table as timer b
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			serial_tick_o <= 1'b0;
		end else begin
			serial_tick_o <= ps_run && (serial_mode_register_i != timer_trio_pkg::EXT_EVENT_CODE)
				&& tap(system_clock_prescaler, shift_b(serial_mode_register_i)); // RQ3
		end
	end

	// ----------------------------------------------------------------
	// prescaler w: sub-oscillator edges divided by eight
	// ----------------------------------------------------------------
	logic sub_q;
	logic sub_rise;
	logic [2:0] sub_div;
	logic [4:0] subclock_prescaler;
	logic sub_cycle;
	logic half_cycle;
	logic ta_clear;

	assign sub_rise = sub_oscillator_input_i && !sub_q;
	assign sub_cycle = sub_rise && (sub_div == timer_trio_pkg::SUB_DIV_TOP); // RQ4
	assign half_cycle = sub_rise && (sub_div[1:0] == timer_trio_pkg::SUB_DIV_TOP[1:0]);
	// codes 14 and 15 hold prescaler w and timer a at zero
	assign ta_clear = timer_a_mode[timer_trio_pkg::WATCH_BASE_BIT]
		&& (timer_a_mode[2:1] == timer_trio_pkg::WBASE_CLEAR_CODE); // RQ9

	// edge detect and divide; the input is already synchronous
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sub_q <= 1'b0;
			sub_div <= 3'h0;
		end else begin
			sub_q <= sub_oscillator_input_i;
			if (sub_rise) begin
				sub_div <= sub_div + 3'h1; // RQ4
			end
		end
	end

	// prescaler w keeps running in watch mode, the time base needs it
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			subclock_prescaler <= timer_trio_pkg::SUBPS_RESET;
		end else if (ta_clear) begin
			subclock_prescaler <= timer_trio_pkg::SUBPS_RESET; // RQ9
		end else if (sub_cycle) begin
			subclock_prescaler <= subclock_prescaler + 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// timer a
	// ----------------------------------------------------------------
	logic [7:0] timer_a_count;
	logic tick_a;
	logic wbase_tick;
	logic ovf_a;
	logic timer_a_irq_flag;

	// prescaler w taps: 32, 16, 8, 2 and half a sub cycle
	always_comb begin
		case (timer_a_mode[2:0])
			3'h0: wbase_tick = sub_cycle && tap({6'h00, subclock_prescaler}, 4'h5);
			3'h1: wbase_tick = sub_cycle && tap({6'h00, subclock_prescaler}, 4'h4);
			3'h2: wbase_tick = sub_cycle && tap({6'h00, subclock_prescaler}, 4'h3);
			3'h3: wbase_tick = sub_cycle && tap({6'h00, subclock_prescaler}, 4'h1);
			timer_trio_pkg::WBASE_HALF_CODE: wbase_tick = half_cycle;
			default: wbase_tick = 1'b0;
		endcase
	end

	// source select by watch base bit
	assign tick_a = timer_a_mode[timer_trio_pkg::WATCH_BASE_BIT] ? wbase_tick // RQ8
		: (ps_run && tap(system_clock_prescaler, shift_ac(timer_a_mode[2:0]))); // RQ23
	assign ovf_a = tick_a && !ta_clear && (timer_a_count == timer_trio_pkg::COUNT_TOP); // RQ7

	// plain 8-bit up counter, natural wrap gives the 256 period
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			timer_a_count <= timer_trio_pkg::COUNT_RESET; // RQ5
		end else if (ta_clear) begin
			timer_a_count <= timer_trio_pkg::COUNT_RESET; // RQ9
		end else if (tick_a) begin
			timer_a_count <= timer_a_count + 8'h01; // RQ5
		end
	end

	// overflow beats a same-cycle software clear
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			timer_a_irq_flag <= 1'b0;
		end else if (ovf_a) begin
			timer_a_irq_flag <= 1'b1; // RQ6
		end else if (req_i.wr && req_i.addr == timer_trio_pkg::ADDR_FLAGS_A
			&& !req_i.wdata[timer_trio_pkg::FLAG_A_BIT]) begin
			timer_a_irq_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// timers b (index 0) and c (index 1)
	// ----------------------------------------------------------------
	logic ext_q;
	logic ext_fall;
	logic [7:0] load_val [2];
	logic [7:0] cnt [2];
	logic [3:0] lo_latch [2];
	logic tick_bc [2];
	logic ovf_bc [2];

	// event input is active low: count falling edges
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ext_q <= 1'b1;
		end else begin
			ext_q <= external_event_input_i;
		end
	end
	assign ext_fall = ext_q && !external_event_input_i; // RQ12

	assign tick_bc[0] = (timer_b_mode[2:0] == timer_trio_pkg::EXT_EVENT_CODE) ? ext_fall // RQ24
		: (ps_run && tap(system_clock_prescaler, shift_b(timer_b_mode[2:0]))); // RQ3
	assign tick_bc[1] = ps_run && tap(system_clock_prescaler, shift_ac(timer_c_mode[2:0])); // RQ20

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_bc
			logic [3:0] lo_addr;
			logic [3:0] hi_addr;
			logic reload_on;
			logic load_hi;
			assign lo_addr = (gi == 0) ? timer_trio_pkg::ADDR_TB_LO : timer_trio_pkg::ADDR_TC_LO;
			assign hi_addr = (gi == 0) ? timer_trio_pkg::ADDR_TB_HI : timer_trio_pkg::ADDR_TC_HI;
			assign reload_on = (gi == 0) ? timer_b_mode[timer_trio_pkg::RELOAD_BIT]
				: timer_c_mode[timer_trio_pkg::RELOAD_BIT];
			assign load_hi = req_i.wr && (req_i.addr == hi_addr);
			assign ovf_bc[gi] = tick_bc[gi] && !load_hi && (cnt[gi] == timer_trio_pkg::COUNT_TOP);

			// load register: low nibble parks, high nibble completes it
			always_ff @(posedge clock_i or negedge rstn_i) begin
				if (!rstn_i) begin
					load_val[gi] <= timer_trio_pkg::COUNT_RESET;
				end else if (req_i.wr && req_i.addr == lo_addr) begin
					load_val[gi][3:0] <= req_i.wdata; // RQ25
				end else if (load_hi) begin
					load_val[gi][7:4] <= req_i.wdata; // RQ25
				end
			end

			// counter: a software load wins over a tick in the same cycle
			always_ff @(posedge clock_i or negedge rstn_i) begin
				if (!rstn_i) begin
					cnt[gi] <= timer_trio_pkg::COUNT_RESET;
				end else if (load_hi) begin
					cnt[gi] <= {req_i.wdata, load_val[gi][3:0]}; // RQ13 RQ17
				end else if (ovf_bc[gi]) begin
					cnt[gi] <= reload_on ? load_val[gi] : timer_trio_pkg::COUNT_RESET; // RQ14 RQ17
				end else if (tick_bc[gi]) begin
					cnt[gi] <= cnt[gi] + 8'h01; // RQ13
				end
			end

			// high read snapshots the low nibble for a coherent pair
			always_ff @(posedge clock_i or negedge rstn_i) begin
				if (!rstn_i) begin
					lo_latch[gi] <= 4'h0;
				end else if (req_i.rd && req_i.addr == hi_addr) begin
					lo_latch[gi] <= cnt[gi][3:0]; // RQ26
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// flags b and c, watchdog, pwm
	// ----------------------------------------------------------------
	logic timer_b_irq_flag;
	logic timer_c_irq_flag;
	logic flags_bc_wr;
	logic pwm;
	logic [7:0] pwm_mid;

	assign flags_bc_wr = req_i.wr && (req_i.addr == timer_trio_pkg::ADDR_FLAGS_BC);

	// writing a zero clears; an overflow in that cycle still sets
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			timer_b_irq_flag <= 1'b0;
			timer_c_irq_flag <= 1'b0;
		end else begin
			if (ovf_bc[0]) begin
				timer_b_irq_flag <= 1'b1; // RQ15
			end else if (flags_bc_wr && !req_i.wdata[timer_trio_pkg::FLAG_B_BIT]) begin
				timer_b_irq_flag <= 1'b0;
			end
			if (ovf_bc[1]) begin
				timer_c_irq_flag <= 1'b1; // RQ18
			end else if (flags_bc_wr && !req_i.wdata[timer_trio_pkg::FLAG_C_BIT]) begin
				timer_c_irq_flag <= 1'b0;
			end
		end
	end

	// one-cycle reset request; only ticking overflows reach it, so a frozen timer c never fires
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			watchdog_reset_o <= 1'b0;
		end else begin
			watchdog_reset_o <= ovf_bc[1] && watchdog_enable_flag; // RQ19 RQ20
		end
	end

	// midpoint of the span the counter walks between overflows
	assign pwm_mid = timer_c_mode[timer_trio_pkg::RELOAD_BIT]
		? (timer_trio_pkg::PWM_MID_BASE + {1'b0, load_val[1][7:1]}) : timer_trio_pkg::PWM_MID_BASE;

	// pwm only moves on ticks, so it freezes with timer c
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pwm <= 1'b0;
		end else if (ovf_bc[1]) begin
			pwm <= 1'b1; // RQ27
		end else if (tick_bc[1] && cnt[1] == pwm_mid) begin
			pwm <= 1'b0; // RQ21 RQ27
		end
	end

	// pin driven only when port select b routes the timer output
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pulse_output_pin_o <= 1'b0;
			pulse_output_en_o <= 1'b0;
		end else begin
			pulse_output_pin_o <= pwm; // RQ21
			pulse_output_en_o <= port_select_mode_b[timer_trio_pkg::PORT_SEL_TIMER_OUT_BIT];
		end
	end

	assign irq_flags_o = {timer_c_irq_flag, timer_b_irq_flag, timer_a_irq_flag};

	// ----------------------------------------------------------------
	// read port: data stands one cycle after the strobe, zero otherwise
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 4'h0;
		end else if (!req_i.rd) begin
			rdata_o <= 4'h0;
		end else begin
			case (req_i.addr)
				timer_trio_pkg::ADDR_FLAGS_A: rdata_o <= {1'b0, timer_a_irq_flag, 2'b00};
				timer_trio_pkg::ADDR_FLAGS_BC: rdata_o <= {1'b0, timer_c_irq_flag, 1'b0, timer_b_irq_flag};
				timer_trio_pkg::ADDR_WDOG: rdata_o <= {3'b000, watchdog_enable_flag};
				timer_trio_pkg::ADDR_PORT_SEL_B: rdata_o <= port_select_mode_b;
				timer_trio_pkg::ADDR_TB_HI: rdata_o <= cnt[0][7:4];
				timer_trio_pkg::ADDR_TB_LO: rdata_o <= lo_latch[0]; // RQ26
				timer_trio_pkg::ADDR_TC_HI: rdata_o <= cnt[1][7:4];
				timer_trio_pkg::ADDR_TC_LO: rdata_o <= lo_latch[1];
				default: rdata_o <= 4'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	property p_ps_run;
		ps_run |=> system_clock_prescaler == $past(system_clock_prescaler) + 11'h001;
	endproperty
	a_ps_run: assert property (p_ps_run) else $error("prescaler s did not advance"); // RQ2

	property p_ps_hold;
		!ps_run |=> $stable(system_clock_prescaler);
	endproperty
	a_ps_hold: assert property (p_ps_hold) else $error("prescaler s moved while paused"); // RQ2

	property p_ta_wrap;
		ovf_a |=> timer_a_count == 8'h00 && timer_a_irq_flag;
	endproperty
	a_ta_wrap: assert property (p_ta_wrap) else $error("timer a wrap or flag missing"); // RQ5 RQ6

	property p_ta_step;
		tick_a && !ta_clear |=> timer_a_count == $past(timer_a_count) + 8'h01;
	endproperty
	a_ta_step: assert property (p_ta_step) else $error("timer a step wrong"); // RQ7

	property p_ta_clear;
		ta_clear ##1 ta_clear |-> timer_a_count == 8'h00 && subclock_prescaler == 5'h00;
	endproperty
	a_ta_clear: assert property (p_ta_clear) else $error("watch clear code did not hold zero"); // RQ9

	property p_tb_load;
		req_i.wr && req_i.addr == timer_trio_pkg::ADDR_TB_HI |=> cnt[0] == {$past(req_i.wdata), load_val[0][3:0]};
	endproperty
	a_tb_load: assert property (p_tb_load) else $error("timer b load mismatch"); // RQ13

	property p_tb_reload;
		ovf_bc[0] && timer_b_mode[3] |=> cnt[0] == $past(load_val[0]) && timer_b_irq_flag;
	endproperty
	a_tb_reload: assert property (p_tb_reload) else $error("timer b reload or flag wrong"); // RQ14 RQ15

	property p_tc_flag;
		ovf_bc[1] |=> timer_c_irq_flag && pwm;
	endproperty
	a_tc_flag: assert property (p_tc_flag) else $error("timer c flag or pwm not set"); // RQ18 RQ27

	property p_wdog;
		ovf_bc[1] && watchdog_enable_flag |=> watchdog_reset_o ##1 !watchdog_reset_o || ovf_bc[1];
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog reset pulse wrong"); // RQ19

	c_ta_ovf: cover property (ovf_a);
	c_tb_ext: cover property (timer_b_mode[2:0] == 3'h7 && ovf_bc[0]);
	c_wdog: cover property (watchdog_reset_o);

endmodule : prescaled_timer_trio

`default_nettype wire

// file: tb/timer_far_side.sv
// far-side model: sub-oscillator, event pin and pulse-pin observer
// assumes one clock domain; the bench calls events() by hierarchy
`timescale 1ns/1ps
`default_nettype none

module timer_far_side (
	// clock
	input wire logic clock_i,
	// sub-oscillator control
	input wire logic sub_run_i,
	// pins toward the timer block
	output logic sub_osc_o,
	output logic event_n_o,
	input wire logic pulse_i,
	input wire logic pulse_en_i
);
	int n_rises = 0;
	int high_len = 0;
	int period = 0;
	int hi_cnt = 0;
	int per_cnt = 0;
	logic pulse_q = 1'b0;

	initial begin
		sub_osc_o = 1'b0;
		event_n_o = 1'b1; // pin idles high through its pull-up
	end

	// sub-oscillator stands low while not running
	always @(posedge clock_i) begin
		sub_osc_o <= sub_run_i ? ~sub_osc_o : 1'b0;
	end

	// pin is routed as event input only, so no interrupt side effect
	task automatic events(input int n);
		repeat (n) begin
			@(posedge clock_i);
			event_n_o <= 1'b0;
			repeat (2) @(posedge clock_i);
			event_n_o <= 1'b1;
			@(posedge clock_i);
		end
	endtask : events

	// period and high time of the pulse pin, only while it is routed out
	always @(posedge clock_i) begin
		pulse_q <= pulse_i;
		per_cnt <= per_cnt + 1;
		hi_cnt <= hi_cnt + 1;
		if (pulse_en_i && pulse_i && !pulse_q) begin
			n_rises <= n_rises + 1;
			period <= per_cnt;
			per_cnt <= 1;
			hi_cnt <= 1;
		end
		if (pulse_en_i && !pulse_i && pulse_q)
			high_len <= hi_cnt;
	end
endmodule : timer_far_side
`default_nettype wire

// file: tb/prescaled_timer_trio_tb.sv
// bench for the timer trio: register tasks, timers, watchdog, pwm, serial tick
// assumes the far-side model drives event and sub-oscillator pins
`timescale 1ns/1ps
`default_nettype none

module prescaled_timer_trio_tb;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	timer_trio_pkg::reg_req_t req = '0;
	timer_trio_pkg::power_mode_t power = '0;
	logic [2:0] ser_code = 3'h7;
	logic sub_run = 1'b0;
	logic [3:0] rdata;
	logic tick, sub_osc, event_n, pulse, pulse_en, wdog;
	logic [2:0] flags;
	logic [3:0] d;
	logic [7:0] v;
	int num_errors = 0;
	int n_checks = 0;
	int n_tick = 0;
	int n_wd = 0;
	int t0;
	int r;
	logic [2:0] sc [4] = '{3'h6, 3'h5, 3'h4, 3'h7};
	int se [4] = '{100, 50, 25, 0};

	always #4 clock_i = ~clock_i;

	// pulse counters for serial tick and watchdog request
	always @(posedge clock_i) begin
		if (tick === 1'b1) n_tick <= n_tick + 1;
		if (wdog === 1'b1) n_wd <= n_wd + 1;
	end

	prescaled_timer_trio DUT (
		.clock_i(clock_i), .rstn_i(rstn_i), .req_i(req), .rdata_o(rdata), .power_i(power),
		.serial_mode_register_i(ser_code), .serial_tick_o(tick), .sub_oscillator_input_i(sub_osc),
		.external_event_input_i(event_n), .pulse_output_pin_o(pulse), .pulse_output_en_o(pulse_en),
		.irq_flags_o(flags), .watchdog_reset_o(wdog)
	);
	timer_far_side far (
		.clock_i(clock_i), .sub_run_i(sub_run), .sub_osc_o(sub_osc), .event_n_o(event_n),
		.pulse_i(pulse), .pulse_en_i(pulse_en)
	);

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [3:0] a, input logic [3:0] w);
		@(posedge clock_i);
		req.addr <= a;
		req.wdata <= w;
		req.wr <= 1'b1;
		@(posedge clock_i);
		req.wr <= 1'b0;
		#1;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [3:0] q);
		@(posedge clock_i);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clock_i);
		req.rd <= 1'b0;
		#1 q = rdata;
	endtask : rd_reg

	// high nibble first, it latches the low one
	task automatic rd_count(input logic [3:0] hi, output logic [7:0] q);
		rd_reg(hi, q[7:4]);
		rd_reg(hi - 4'h1, q[3:0]);
	endtask : rd_count

	task automatic wait_flag(input int idx, input int limit);
		int k;
		k = 0;
		while (flags[idx] !== 1'b1 && k < limit) begin
			@(posedge clock_i);
			k++;
		end
		#1;
	endtask : wait_flag

	task automatic results;
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clock_i);
		rstn_i <= 1'b1;
		// reset state, write-only and unmapped reads
		rd_reg(timer_trio_pkg::ADDR_FLAGS_BC, d);
		check(d, 8'h00);
		rd_reg(timer_trio_pkg::ADDR_MODE_B, d);
		check(d, 8'h00);
		rd_reg(4'hc, d);
		check(d, 8'h00);
		$display("reset test done");
		// timer b on external events, with and without reload
		wr_reg(timer_trio_pkg::ADDR_MODE_B, 4'hf);
		wr_reg(timer_trio_pkg::ADDR_TB_LO, 4'hd);
		wr_reg(timer_trio_pkg::ADDR_TB_HI, 4'hf);
		rd_count(timer_trio_pkg::ADDR_TB_HI, v);
		check(v, 8'hfd);
		check(flags[1], 8'h00);
		far.events(3);
		repeat (3) @(posedge clock_i);
		check(flags[1], 8'h01);
		rd_count(timer_trio_pkg::ADDR_TB_HI, v);
		check(v, 8'hfd);
		wr_reg(timer_trio_pkg::ADDR_MODE_B, 4'h7);
		wr_reg(timer_trio_pkg::ADDR_TB_LO, 4'he);
		wr_reg(timer_trio_pkg::ADDR_TB_HI, 4'hf);
		far.events(3);
		repeat (3) @(posedge clock_i);
		rd_count(timer_trio_pkg::ADDR_TB_HI, v);
		check(v, 8'h01);
		wr_reg(timer_trio_pkg::ADDR_FLAGS_BC, 4'h0);
		check(flags[1], 8'h00);
		$display("timer b test done");
		// timer a from prescaler s at the fastest rate
		wr_reg(timer_trio_pkg::ADDR_MODE_A, 4'he);
		wr_reg(timer_trio_pkg::ADDR_MODE_A, 4'h7);
		rd_reg(timer_trio_pkg::ADDR_MODE_A, d);
		check(d, 8'h00);
		repeat (500) @(posedge clock_i);
		check(flags[0], 8'h00);
		wait_flag(0, 30);
		check(flags[0], 8'h01);
		wr_reg(timer_trio_pkg::ADDR_FLAGS_A, 4'h0);
		$display("timer a test done");
		// watch time base: held clear, then counting prescaler w
		wr_reg(timer_trio_pkg::ADDR_MODE_A, 4'he);
		sub_run <= 1'b1;
		repeat (2500) @(posedge clock_i);
		check(flags[0], 8'h00);
		wr_reg(timer_trio_pkg::ADDR_MODE_A, 4'hc);
		repeat (2000) @(posedge clock_i);
		check(flags[0], 8'h00);
		wait_flag(0, 100);
		check(flags[0], 8'h01);
		sub_run <= 1'b0;
		$display("watch base test done");
		// timer c with reload, watchdog and pulse output
		wr_reg(timer_trio_pkg::ADDR_PORT_SEL_B, 4'h4);
		// pin enable is registered one cycle behind the select bit
		wr_reg(timer_trio_pkg::ADDR_MODE_C, 4'hf);
		check(pulse_en, 8'h01);
		wr_reg(timer_trio_pkg::ADDR_TC_LO, 4'h0);
		wr_reg(timer_trio_pkg::ADDR_TC_HI, 4'hf);
		wr_reg(timer_trio_pkg::ADDR_WDOG, 4'h1);
		t0 = n_wd;
		wait_flag(2, 60);
		check(flags[2], 8'h01);
		repeat (2) @(posedge clock_i);
		check(8'(n_wd - t0), 8'h01);
		repeat (100) @(posedge clock_i);
		check(8'(far.period), 8'd32);
		check(8'(far.high_len >= 14 && far.high_len <= 18), 8'h01);
		$display("timer c test done");
		// stop then watch freeze timer c, watchdog and pulse
		for (int i = 0; i < 2; i++) begin
			power <= (i == 0) ? 2'b10 : 2'b01;
			wr_reg(timer_trio_pkg::ADDR_FLAGS_BC, 4'h0);
			t0 = n_wd;
			r = far.n_rises;
			repeat (200) @(posedge clock_i);
			check(flags[2], 8'h00);
			check(8'(n_wd - t0), 8'h00);
			check(8'(far.n_rises - r), 8'h00);
			power <= '0;
			wait_flag(2, 40);
			check(flags[2], 8'h01);
		end
		wr_reg(timer_trio_pkg::ADDR_WDOG, 4'h0);
		$display("power mode test done");
		// serial tick rates from prescaler s taps
		for (int i = 0; i < 4; i++) begin
			ser_code <= sc[i];
			repeat (4) @(posedge clock_i);
			t0 = n_tick;
			repeat (200) @(posedge clock_i);
			check(8'(n_tick - t0), 8'(se[i]));
		end
		$display("serial tick test done");
		results();
	end

	// hang guard, well past the expected run length
	initial begin
		#160000;
		num_errors++;
		$display("timeout reached");
		results();
	end
endmodule : prescaled_timer_trio_tb
`default_nettype wire
